// file: hdl/apc_decode.sv
`include "apc_map.svh"
// Maps an analog gain code to a mute flag and an effective gain code.
module apc_decode
  import apc_pkg::*;
(
  input  wire logic [1:0] i_code,
  output logic            o_mute,
  output logic [1:0]      o_gain
);
  // Code 11 mutes and leaves the gain at its 0 dB code.
  always_comb begin
    o_mute = (i_code == `APC_GAIN_MUTE);
    o_gain = o_mute ? 2'h0 : i_code;
  end
endmodule : apc_decode

// file: hdl/apc_map.svh
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

// Register indices; byte address is four times the index.
`define APC_IDX_RXS_HIGH   8'h05
`define APC_IDX_PART_ID    8'h06
`define APC_IDX_LOOPBACK   8'h08
`define APC_IDX_GAIN       8'h09
`define APC_IDX_IMPEDANCE  8'h0a

// Writable bit masks per register.
`define APC_MASK_RXS_HIGH  8'h03
`define APC_MASK_LOOPBACK  8'h07
`define APC_MASK_GAIN      8'hff
`define APC_MASK_IMPEDANCE 8'h3f

// Reset values.
`define APC_RST_RXS_HIGH   8'h00
`define APC_RST_LOOPBACK   8'h02
`define APC_RST_GAIN       8'h00
`define APC_RST_IMPEDANCE  8'h00

// Field positions.
`define APC_POS_FULL_ALB   2
`define APC_POS_DIG_LB     1
`define APC_POS_FIRST_ALB  0
`define APC_POS_RX_HIGHPASS_BYPASS       7
`define APC_POS_TX_HIGHPASS_BYPASS       6
`define APC_POS_TXM        5
`define APC_POS_RXM        4
`define APC_POS_ATX        2
`define APC_POS_ARX        0
`define APC_POS_CLC        4
`define APC_POS_IMPEDANCE_SYNTH_ENABLE       3
`define APC_POS_IMPEDANCE_PROFILE_SELECT       0
`define APC_POS_PART_ID    5

// Gain code that mutes the analog path.
`define APC_GAIN_MUTE      2'h3
`define APC_CLC_RESERVED   2'h3
`endif

// file: hdl/apc_pkg.sv
package apc_pkg;
  typedef logic [7:0] apc_byte_t;

  // One-hot bus answer sequencer states.
  typedef enum logic [1:0] {
    APC_IDLE = 2'b01,
    APC_DONE = 2'b10
  } apc_bus_e;

  typedef struct packed {
    apc_bus_e  st;
    apc_byte_t rxs_high;
    apc_byte_t loopback;
    apc_byte_t gain;
    apc_byte_t impedance;
    logic [31:0] rdata;
  } apc_state_s;
endpackage : apc_pkg

// file: hdl/apc_regs.sv
`include "apc_map.svh"
// Audio path control register bank on an Avalon-MM slave port.
module apc_regs
  import apc_pkg::*;
#(
  parameter logic [2:0] PART_ID = 3'h5  // Arbitrary neutral identity value.
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  output logic [1:0]       o_rxs_high,
  output logic             o_full_analog_loopback,
  output logic             o_digital_loopback,
  output logic             o_first_analog_loopback,
  output logic             o_rx_highpass_bypass,
  output logic             o_tx_highpass_bypass,
  output logic             o_tx_mute,
  output logic             o_rx_mute,
  output logic [1:0]       o_analog_tx_gain,
  output logic             o_analog_tx_mute,
  output logic [1:0]       o_analog_rx_gain,
  output logic             o_analog_rx_mute,
  output logic [1:0]       o_line_cap_compensation,
  output logic             o_impedance_synth_enable,
  output logic [2:0]       o_impedance_profile_select
);
  apc_state_s s_q;
  apc_state_s s_d;
  logic [7:0] idx;
  logic       wr_lane;

  // Byte address to register index; low two bits are the byte within the word.
  function automatic logic [7:0] word_idx(input logic [7:0] a);
    return {2'h0, a[7:2]};
  endfunction : word_idx

  // Read value for an index; reserved bits and unmapped words read zero.
  function automatic logic [7:0] rd_val(input logic [7:0] i, input apc_state_s s);
    case (i)
      `APC_IDX_RXS_HIGH:  rd_val = s.rxs_high & `APC_MASK_RXS_HIGH;
      `APC_IDX_PART_ID:   rd_val = {PART_ID, 5'h00};
      `APC_IDX_LOOPBACK:  rd_val = s.loopback & `APC_MASK_LOOPBACK;
      `APC_IDX_GAIN:      rd_val = s.gain;
      `APC_IDX_IMPEDANCE: rd_val = s.impedance & `APC_MASK_IMPEDANCE;
      default:            rd_val = 8'h00;
    endcase
  endfunction : rd_val

  assign idx     = word_idx(i_address);
  assign wr_lane = i_byteenable[0];

  // Each request is answered one cycle after it is seen, then released.
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      APC_IDLE: begin
        if (i_read || i_write) begin
          s_d.st    = APC_DONE;
          s_d.rdata = {24'h000000, rd_val(idx, s_q)};
          if (i_write && wr_lane) begin
            case (idx)
              `APC_IDX_RXS_HIGH:  s_d.rxs_high  = i_writedata[7:0] & `APC_MASK_RXS_HIGH;
              `APC_IDX_LOOPBACK:  s_d.loopback  = i_writedata[7:0] & `APC_MASK_LOOPBACK;
              `APC_IDX_GAIN:      s_d.gain      = i_writedata[7:0] & `APC_MASK_GAIN;
              `APC_IDX_IMPEDANCE: s_d.impedance = i_writedata[7:0] & `APC_MASK_IMPEDANCE;
              default: begin
              end
            endcase
          end
        end
      end
      APC_DONE: begin
        s_d.st = APC_IDLE;
      end
      default: begin
        s_d.st = APC_IDLE;
      end
    endcase
  end

  // Register the whole state; reset takes constants only.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q.st        <= APC_IDLE;
      s_q.rxs_high  <= `APC_RST_RXS_HIGH;
      s_q.loopback  <= `APC_RST_LOOPBACK;
      s_q.gain      <= `APC_RST_GAIN;
      s_q.impedance <= `APC_RST_IMPEDANCE;
      s_q.rdata     <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  // Waitrequest drops in the answer cycle so the master samples it there.
  assign o_waitrequest = (s_q.st != APC_DONE);
  assign o_readdata    = s_q.rdata;

  assign o_rxs_high = s_q.rxs_high[1:0];
  assign o_full_analog_loopback  = s_q.loopback[`APC_POS_FULL_ALB];
  assign o_digital_loopback      = s_q.loopback[`APC_POS_DIG_LB];
  assign o_first_analog_loopback = s_q.loopback[`APC_POS_FIRST_ALB];
  assign o_rx_highpass_bypass    = s_q.gain[`APC_POS_RX_HIGHPASS_BYPASS];
  assign o_tx_highpass_bypass    = s_q.gain[`APC_POS_TX_HIGHPASS_BYPASS];
  assign o_tx_mute               = s_q.gain[`APC_POS_TXM];
  assign o_rx_mute               = s_q.gain[`APC_POS_RXM];

  apc_decode u_tx_gain (
    .i_code (s_q.gain[`APC_POS_ATX +: 2]),
    .o_mute (o_analog_tx_mute),
    .o_gain (o_analog_tx_gain)
  );

  apc_decode u_rx_gain (
    .i_code (s_q.gain[`APC_POS_ARX +: 2]),
    .o_mute (o_analog_rx_mute),
    .o_gain (o_analog_rx_gain)
  );

  // Capacitance code passes as stored; the reserved code is software's to avoid.
  assign o_line_cap_compensation    = s_q.impedance[`APC_POS_CLC +: 2];
  assign o_impedance_synth_enable   = s_q.impedance[`APC_POS_IMPEDANCE_SYNTH_ENABLE];
  assign o_impedance_profile_select = s_q.impedance[`APC_POS_IMPEDANCE_PROFILE_SELECT +: 3];
endmodule : apc_regs

// file: verif/apc_props.sv
module apc_props (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [7:0]  i_address,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0]  i_byteenable,
  input wire logic        o_waitrequest,
  input wire logic [31:0] o_readdata,
  input wire logic        o_digital_loopback,
  input wire logic [1:0]  o_rxs_high,
  input wire logic [1:0]  o_analog_tx_gain,
  input wire logic        o_analog_tx_mute
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // A request is taken while idle; a write is done in its answer cycle.
  sequence s_taken; (i_read || i_write) && o_waitrequest; endsequence
  sequence s_wr(a); i_write && i_byteenable[0] && !o_waitrequest && i_address == a; endsequence
  a_wait_answer: assert property (s_taken |=> !o_waitrequest) else $error("no answer");
  a_wait_single: assert property (!o_waitrequest |=> o_waitrequest) else $error("answer too long");
  a_rd_upper: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_pid_low: assert property (s_taken ##1 i_address == 8'h18 |-> o_readdata[4:0] == 5'h0)
    else $error("id low bits set");
  a_rxs_write: assert property (s_wr(8'h14) |-> o_rxs_high == i_writedata[1:0])
    else $error("start count not written");
  a_lb_write: assert property (s_wr(8'h20) |-> o_digital_loopback == i_writedata[1])
    else $error("loopback not written");
  a_tx_mute: assert property (s_wr(8'h24) |-> o_analog_tx_mute == &i_writedata[3:2])
    else $error("tx mute wrong");
  a_tx_zero: assert property (o_analog_tx_mute |-> o_analog_tx_gain == 2'h0)
    else $error("muted gain not zero");
endmodule : apc_props

// file: verif/tb_apc_regs.sv
module tb_apc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] PID = 3'h6;  // Arbitrary identity value.
  logic i_clk, i_arst_n, i_read, i_write, o_waitrequest, o_full_analog_loopback, o_digital_loopback;
  logic o_first_analog_loopback, o_rx_highpass_bypass, o_tx_highpass_bypass, o_tx_mute, o_rx_mute;
  logic o_analog_tx_mute, o_analog_rx_mute, o_impedance_synth_enable;
  logic [1:0] o_rxs_high, o_analog_tx_gain, o_analog_rx_gain, o_line_cap_compensation;
  logic [2:0] o_impedance_profile_select;
  logic [3:0] i_byteenable;
  logic [7:0] i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [7:0] m [16];
  logic [3:0] rw [4] = '{4'h5, 4'h8, 4'h9, 4'ha};
  logic [52:0] q [$];
  logic [52:0] e;
  int fails, samples_checked;
  wire logic [20:0] ov = {o_rxs_high, o_full_analog_loopback, o_digital_loopback, o_first_analog_loopback,
    o_rx_highpass_bypass, o_tx_highpass_bypass, o_tx_mute, o_rx_mute, o_analog_tx_gain, o_analog_tx_mute,
    o_analog_rx_gain, o_analog_rx_mute, o_line_cap_compensation, o_impedance_synth_enable,
    o_impedance_profile_select};
  apc_regs #(.PART_ID(PID)) u_apc_regs (.*);
  initial begin
    i_clk = 0;
    forever #20 i_clk = ~i_clk;
  end
  // Expected control outputs from the register mirror; code 11 mutes and zeroes the gain.
  function automatic logic [20:0] outs();
    return {m[5][1:0], m[8][2:0], m[9][7:4], (&m[9][3:2]) ? 2'h0 : m[9][3:2], &m[9][3:2],
      (&m[9][1:0]) ? 2'h0 : m[9][1:0], &m[9][1:0], m[10][5:0]};
  endfunction : outs
  function automatic logic [7:0] msk(input logic [3:0] x);
    case (x)
      4'h5: return 8'h03;
      4'h8: return 8'h07;
      4'h9: return 8'hff;
      4'ha: return 8'h3f;
      default: return 8'h00;
    endcase
  endfunction : msk
  // One bus cycle; the request is held until waitrequest is seen low.
  task automatic acc(input logic w, input logic [3:0] x, input logic [7:0] d, input logic [3:0] be);
    int n;
    logic [23:0] r;
    r = 24'($urandom());
    @(posedge i_clk);
    i_address <= {2'h0, x, 2'h0};
    i_write <= w;
    i_read <= !w;
    i_writedata <= {r, d};
    i_byteenable <= be;
    if (w && be[0]) m[x] = d & msk(x);
    if (!w) q.push_back({24'h0, (x == 4'h6) ? {PID, 5'h0} : m[x], outs()});
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (n == 50) begin
      fails++;
      $display("wrong value waitrequest exp 0 got %b", o_waitrequest);
    end
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : acc
  task automatic rst();
    i_arst_n <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    m = '{default: 8'h00};
    m[8] = 8'h02;
  endtask : rst
  // Each read answer is compared with the oldest note.
  always @(posedge i_clk) begin
    if (i_read && o_waitrequest === 1'b0) begin
      e = q.pop_front();
      samples_checked++;
      // Readback word and control levels.
      if ({o_readdata, ov} !== e) begin
        fails++;
        $display("wrong value readback exp %h got %h", e, {o_readdata, ov});
      end
    end
  end
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    {i_read, i_write, i_address, i_writedata, i_byteenable} <= '0;
    void'($urandom(32'hac05));
    rst();
    for (int i = 0; i < 16; i++) acc(1'b0, i[3:0], 8'h00, 4'hf);
    $display("test reset_values done");
    repeat (10) foreach (rw[k]) begin
      acc(1'b1, rw[k], 8'($urandom()), 4'hf);
      acc(1'b0, rw[k], 8'h00, 4'hf);
    end
    $display("test random_rw done");
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 4'h9, {4{c[1:0]}}, 4'hf);
      acc(1'b0, 4'h9, 8'h00, 4'hf);
    end
    $display("test gain_codes done");
    acc(1'b1, 4'h6, 8'hff, 4'hf);
    acc(1'b1, 4'h7, 8'hff, 4'hf);
    acc(1'b1, 4'h8, 8'h05, 4'he);
    for (int i = 6; i < 9; i++) acc(1'b0, i[3:0], 8'h00, 4'hf);
    $display("test ignored_writes done");
    acc(1'b1, 4'h8, 8'h00, 4'hf);
    rst();
    acc(1'b0, 4'h8, 8'h00, 4'hf);
    $display("test second_reset done");
    print_verdict();
  end
endmodule : tb_apc_regs
bind apc_regs apc_props u_apc_props (.*);
